/* File: verilog/tcx_map.vh */
/*
  constants for the trap-compare / exclusive-or execution unit:
  instruction field positions, opcode and extended-opcode values, mask bit
  positions and condition field bit positions.
  assumes big-endian bit numbering of the instruction word mapped to
  verilog [31:0] with instruction bit 0 at verilog bit 31.
*/
`ifndef TCX_MAP_VH
`define TCX_MAP_VH

// primary opcode field, instruction bits 0..5
`define TCX_PRI_HI        31
`define TCX_PRI_LO        26
// first register field (mask for traps, source for xor), bits 6..10
`define TCX_F1_HI         25
`define TCX_F1_LO         21
// second register field, bits 11..15
`define TCX_F2_HI         20
`define TCX_F2_LO         16
// third register field, bits 16..20
`define TCX_F3_HI         15
`define TCX_F3_LO         11
// extended opcode, bits 21..30
`define TCX_XO_HI         10
`define TCX_XO_LO         1
// record bit, bit 31
`define TCX_RC_BIT        0
// immediate field, bits 16..31
`define TCX_IMM_HI        15
`define TCX_IMM_LO        0

// primary opcodes
`define TCX_PRI_TRAP_IMM  6'h03
`define TCX_PRI_XOR_LO    6'h1a
`define TCX_PRI_XOR_HI    6'h1b
`define TCX_PRI_EXT       6'h1f
// extended opcodes under the extended primary opcode
`define TCX_XO_TRAP_REG   10'h004
`define TCX_XO_XOR_REG    10'h13c

// trap condition mask bit positions
`define TCX_TM_SLT        0
`define TCX_TM_SGT        1
`define TCX_TM_EQ         2
`define TCX_TM_ULT        3
`define TCX_TM_UGT        4

// condition field layout {less, greater, same, summary overflow}
`define TCX_CF_LT         3
`define TCX_CF_GT         2
`define TCX_CF_EQ         1
`define TCX_CF_SO         0

// fill values
`define TCX_HALF_ZERO     16'h0000
`define TCX_WORD_ZERO     32'h0000_0000
`define TCX_REG_ZERO      5'h00
`define TCX_CF_ZERO       4'h0

// word and half-word geometry used by the extension and condition field logic
`define TCX_WORD_MSB      31
`define TCX_HALF_MSB      15
`define TCX_HALF_W        16

`endif

/* File: verilog/tcx_cond.v */
/*
  combinational comparator for the trap-compare unit: evaluates the five
  trap conditions on two 32-bit operands and gates them with the mask.
  assumes operands are already extended to 32 bits by the caller.
*/
`timescale 1ns/1ps
`include "tcx_map.vh"

module tcx_cond (
  // operands
  input  wire [31:0] opnd_a,
  input  wire [31:0] opnd_b,
  // enable mask
  input  wire [4:0]  trap_condition_mask,
  // result
  output wire [4:0]  cond_hits,
  output wire        trap_hit
);

  wire [4:0] cond_raw;

  // signed compares and equality on the three low mask bits
  assign cond_raw[`TCX_TM_SLT] = $signed(opnd_a) < $signed(opnd_b);
  assign cond_raw[`TCX_TM_SGT] = $signed(opnd_a) > $signed(opnd_b);
  assign cond_raw[`TCX_TM_EQ]  = opnd_a == opnd_b;
  // unsigned compares on the two high mask bits
  assign cond_raw[`TCX_TM_ULT] = opnd_a < opnd_b;
  assign cond_raw[`TCX_TM_UGT] = opnd_a > opnd_b;

  // any enabled condition that holds traps
  assign cond_hits = cond_raw & trap_condition_mask;
  assign trap_hit  = |cond_hits;

endmodule

/* File: verilog/tcx_unit.v */
/*
  execution unit for the word trap instructions (register and immediate
  forms) and the exclusive-or instructions (register, low and high
  immediate forms). one pipeline stage: results appear one clock after issue.
  instruction fields, counted from the msb of instr_word:
    [31:26] primary opcode, [25:21] trap mask or xor source register,
    [20:16] xor destination / first trap operand register,
    [15:11] second register, [10:1] extended opcode, [0] record bit,
    [15:0] immediate of the d-form operations.
  the five-bit trap mask is numbered from its msb, so mask bit 0 is
  instr_word[25] and mask bit 4 is instr_word[21].
  assumes decode/issue presents the instruction word with its register
  operands already read, and that the core's register file and condition
  register take the writeback strobes from this unit.
*/
`timescale 1ns/1ps
`include "tcx_map.vh"

module tcx_unit (
  // clock and reset
  input  wire        mclk,
  input  wire        reset_n,
  // issue side
  input  wire        issue_valid,
  input  wire [31:0] instr_word,
  input  wire [31:0] reg_a_value,
  input  wire [31:0] reg_b_value,
  input  wire [31:0] source_reg_value,
  input  wire        summary_overflow,
  // general register writeback
  output reg         gpr_we_q,
  output reg  [4:0]  gpr_waddr_q,
  output reg  [31:0] gpr_wdata_q,
  // condition field 0 writeback
  output reg         cf0_we_q,
  output reg  [3:0]  first_condition_field_q,
  // exception request
  output reg         prog_exc_req_q,
  output reg         trap_cause_q,
  // completion and decode status
  output reg         done_q,
  output reg         claimed_q
);

  // sign extension of a 16-bit field to a word
  function [31:0] sign_extend;
    input [15:0] v;
    begin
      sign_extend = {{`TCX_HALF_W{v[`TCX_HALF_MSB]}}, v};
    end
  endfunction

  // mask field is numbered from its msb: bring mask bit n to index n
  function [4:0] mask_order;
    input [4:0] fld;
    begin
      mask_order[`TCX_TM_SLT] = fld[`TCX_TM_UGT];
      mask_order[`TCX_TM_SGT] = fld[`TCX_TM_ULT];
      mask_order[`TCX_TM_EQ]  = fld[`TCX_TM_EQ];
      mask_order[`TCX_TM_ULT] = fld[`TCX_TM_SGT];
      mask_order[`TCX_TM_UGT] = fld[`TCX_TM_SLT];
    end
  endfunction

  // extended-form decode: extended primary opcode plus one extended opcode
  function ext_match;
    input [5:0] pri;
    input [9:0] xo;
    input [9:0] want;
    begin
      ext_match = (pri == `TCX_PRI_EXT) && (xo == want);
    end
  endfunction

  // condition field image of a result: sign, positive, zero, overflow copy
  function [3:0] cond_image;
    input [31:0] res;
    input        so;
    begin
      cond_image             = `TCX_CF_ZERO;
      cond_image[`TCX_CF_LT] = res[`TCX_WORD_MSB];
      cond_image[`TCX_CF_GT] = ~res[`TCX_WORD_MSB] & (res != `TCX_WORD_ZERO);
      cond_image[`TCX_CF_EQ] = (res == `TCX_WORD_ZERO);
      cond_image[`TCX_CF_SO] = so;
    end
  endfunction

  // field extraction
  wire [5:0]  pri_op              = instr_word[`TCX_PRI_HI:`TCX_PRI_LO];
  wire [9:0]  ext_op              = instr_word[`TCX_XO_HI:`TCX_XO_LO];
  wire [4:0]  f1                  = instr_word[`TCX_F1_HI:`TCX_F1_LO];
  wire [4:0]  f2                  = instr_word[`TCX_F2_HI:`TCX_F2_LO];
  wire        record_bit          = instr_word[`TCX_RC_BIT];
  wire [15:0] imm16               = instr_word[`TCX_IMM_HI:`TCX_IMM_LO];
  // operand naming per instruction form
  wire [4:0]  trap_condition_mask = mask_order(f1);
  wire [4:0]  reg_a_field         = f2;
  wire [15:0] signed_immediate    = imm16;
  wire [15:0] unsigned_immediate  = imm16;

  // decode of the five operations
  wire is_trap_reg = ext_match(pri_op, ext_op, `TCX_XO_TRAP_REG);
  wire is_trap_imm = (pri_op == `TCX_PRI_TRAP_IMM);
  wire is_xor_reg  = ext_match(pri_op, ext_op, `TCX_XO_XOR_REG);
  wire is_xor_lo   = (pri_op == `TCX_PRI_XOR_LO);
  wire is_xor_hi   = (pri_op == `TCX_PRI_XOR_HI);
  // form groups
  wire is_trap     = is_trap_reg | is_trap_imm;
  wire is_xor      = is_xor_reg | is_xor_lo | is_xor_hi;

  // second compare operand: register or extended immediate
  wire [31:0] cmp_b = is_trap_imm ? sign_extend(signed_immediate) : reg_b_value;

  // trap decision from the comparator
  wire        trap_hit;

  // condition evaluation shared by both trap forms
  tcx_cond u_cond (
    .opnd_a              (reg_a_value),
    .opnd_b              (cmp_b),
    .trap_condition_mask (trap_condition_mask),
    .cond_hits           (),
    .trap_hit            (trap_hit)
  );

  // exclusive-or result for the three xor forms
  reg [31:0] xor_res;
  always @* begin
    if (is_xor_lo) begin
      xor_res = source_reg_value ^ {`TCX_HALF_ZERO, unsigned_immediate};
    end else if (is_xor_hi) begin
      xor_res = source_reg_value ^ {unsigned_immediate, `TCX_HALF_ZERO};
    end else begin
      xor_res = source_reg_value ^ reg_b_value;
    end
  end

  // next values of the result registers
  reg        gpr_we_d;
  reg [4:0]  gpr_waddr_d;
  reg [31:0] gpr_wdata_d;
  reg        cf0_we_d;
  reg [3:0]  first_condition_field_d;
  reg        prog_exc_req_d;
  reg        trap_cause_d;
  reg        done_d;
  reg        claimed_d;

  // next-value selection; data outputs hold between xor operations
  always @* begin
    // strobes drop, data holds
    gpr_we_d                = 1'b0;
    gpr_waddr_d             = gpr_waddr_q;
    gpr_wdata_d             = gpr_wdata_q;
    cf0_we_d                = 1'b0;
    first_condition_field_d = first_condition_field_q;
    prog_exc_req_d          = 1'b0;
    trap_cause_d            = 1'b0;
    done_d                  = 1'b0;
    claimed_d               = 1'b0;
    if (issue_valid) begin
      if (is_trap) begin
        // taken or not, a trap writes no register
        done_d         = 1'b1;
        claimed_d      = 1'b1;
        prog_exc_req_d = trap_hit;
        trap_cause_d   = trap_hit;
      end else if (is_xor) begin
        done_d      = 1'b1;
        claimed_d   = 1'b1;
        gpr_we_d    = 1'b1;
        gpr_waddr_d = reg_a_field;
        gpr_wdata_d = xor_res;
        if (is_xor_reg && record_bit) begin
          cf0_we_d                = 1'b1;
          first_condition_field_d = cond_image(xor_res, summary_overflow);
        end
      end
    end
  end

  // strobe registers: each pulse lasts one clock
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gpr_we_q       <= 1'b0;
      cf0_we_q       <= 1'b0;
      prog_exc_req_q <= 1'b0;
      trap_cause_q   <= 1'b0;
      done_q         <= 1'b0;
      claimed_q      <= 1'b0;
    end else begin
      gpr_we_q       <= gpr_we_d;
      cf0_we_q       <= cf0_we_d;
      prog_exc_req_q <= prog_exc_req_d;
      trap_cause_q   <= trap_cause_d;
      done_q         <= done_d;
      claimed_q      <= claimed_d;
    end
  end

  // writeback address and data, held until the next xor
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gpr_waddr_q <= `TCX_REG_ZERO;
      gpr_wdata_q <= `TCX_WORD_ZERO;
    end else begin
      gpr_waddr_q <= gpr_waddr_d;
      gpr_wdata_q <= gpr_wdata_d;
    end
  end

  // condition field 0 image, held until the next recording xor
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      first_condition_field_q <= `TCX_CF_ZERO;
    end else begin
      first_condition_field_q <= first_condition_field_d;
    end
  end

endmodule

/* File: tb/tcx_unit_sva.sv */
/* checker for tcx_unit ports.
   assumes it is bound to every tcx_unit instance */
`timescale 1ns/1ps
module tcx_unit_sva (
  input wire        mclk,
  input wire        reset_n,
  input wire        issue_valid,
  input wire [31:0] instr_word,
  input wire [31:0] reg_a_value,
  input wire [31:0] reg_b_value,
  input wire [31:0] source_reg_value,
  input wire        summary_overflow,
  input wire        gpr_we_q,
  input wire [4:0]  gpr_waddr_q,
  input wire [31:0] gpr_wdata_q,
  input wire        cf0_we_q,
  input wire [3:0]  first_condition_field_q,
  input wire        prog_exc_req_q,
  input wire        trap_cause_q,
  input wire        done_q,
  input wire        claimed_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // decode of the issued word
  wire [15:0] imm = instr_word[15:0];
  wire        xr  = issue_valid && instr_word[31:26] == 6'h1f && instr_word[10:1] == 10'h13c;
  wire        tr  = issue_valid && instr_word[31:26] == 6'h1f && instr_word[10:1] == 10'h004;
  wire        ti  = issue_valid && instr_word[31:26] == 6'h03;
  wire        xl  = issue_valid && instr_word[31:26] == 6'h1a;
  wire        xh  = issue_valid && instr_word[31:26] == 6'h1b;
  // expected values formed at the issue edge
  wire [4:0]  dst = instr_word[20:16];
  wire [31:0] xv  = source_reg_value ^ reg_b_value;
  wire [31:0] xvl = source_reg_value ^ {16'h0000, imm};
  wire [31:0] xvh = source_reg_value ^ {imm, 16'h0000};
  wire [31:0] sxi = {{16{imm[15]}}, imm};
  wire [3:0]  cfx = {xv[31], !xv[31] && xv != 32'h0, xv == 32'h0, summary_overflow};
  a_xor_reg: assert property (xr |=> gpr_we_q && gpr_waddr_q == $past(dst) &&
    gpr_wdata_q == $past(xv)) else $error("register xor result wrong");
  a_xor_low: assert property (xl |=> gpr_we_q && !cf0_we_q &&
    gpr_wdata_q == $past(xvl)) else $error("low xor result wrong");
  a_xor_high: assert property (xh |=> gpr_we_q && !cf0_we_q &&
    gpr_wdata_q == $past(xvh)) else $error("high xor result wrong");
  a_rec_field: assert property (xr && instr_word[0] |=> cf0_we_q && first_condition_field_q == $past(cfx))
    else $error("field 0 update wrong");
  a_norec_field: assert property (xr && !instr_word[0] |=> !cf0_we_q) else $error("field 0 written");
  a_trap_equal: assert property (tr && instr_word[23] && reg_a_value == reg_b_value |=> prog_exc_req_q)
    else $error("equal trap missed");
  a_imm_signed: assert property (ti && instr_word[24] &&
    $signed(reg_a_value) > $signed(sxi) |=> prog_exc_req_q) else $error("imm trap missed");
  a_trap_uless: assert property (tr && instr_word[22] && reg_a_value < reg_b_value |=> prog_exc_req_q)
    else $error("unsigned less trap missed");
  a_trap_nowb: assert property (prog_exc_req_q |-> trap_cause_q && done_q && !gpr_we_q && !cf0_we_q)
    else $error("trap with writeback");
  a_empty_mask: assert property ((tr || ti) && instr_word[25:21] == 5'h00 |=>
    done_q && !prog_exc_req_q && !gpr_we_q) else $error("empty mask trapped");
  c_trap: cover property (prog_exc_req_q);
  c_rec: cover property (cf0_we_q);
  c_quiet: cover property (done_q && !prog_exc_req_q && !gpr_we_q);
endmodule
bind tcx_unit tcx_unit_sva i_sva (
  .mclk                    (mclk),
  .reset_n                 (reset_n),
  .issue_valid             (issue_valid),
  .instr_word              (instr_word),
  .reg_a_value             (reg_a_value),
  .reg_b_value             (reg_b_value),
  .source_reg_value        (source_reg_value),
  .summary_overflow        (summary_overflow),
  .gpr_we_q                (gpr_we_q),
  .gpr_waddr_q             (gpr_waddr_q),
  .gpr_wdata_q             (gpr_wdata_q),
  .cf0_we_q                (cf0_we_q),
  .first_condition_field_q (first_condition_field_q),
  .prog_exc_req_q          (prog_exc_req_q),
  .trap_cause_q            (trap_cause_q),
  .done_q                  (done_q),
  .claimed_q               (claimed_q)
);

/* File: tb/tcx_issue_model.sv */
/* issue-side model: presents one instruction with its operands.
   assumes the bench raises req for one clock per instruction */
`timescale 1ns/1ps
module tcx_issue_model (
  input  wire        req,
  input  wire [31:0] req_word,
  input  wire [31:0] req_a,
  input  wire [31:0] req_b,
  input  wire [31:0] req_s,
  output wire        issue_valid,
  output wire [31:0] instr_word,
  output wire [31:0] reg_a_value,
  output wire [31:0] reg_b_value,
  output wire [31:0] source_reg_value
);
  // idle cycles show inverted values so stale data never matches
  assign issue_valid      = req;
  assign instr_word       = req ? req_word : ~req_word;
  assign reg_a_value      = req ? req_a : ~req_a;
  assign reg_b_value      = req ? req_b : ~req_b;
  assign source_reg_value = req ? req_s : ~req_s;
endmodule

/* File: tb/tb_top.sv */
/* self-checking bench for tcx_unit.
   assumes the issue model and the bound checker */
`timescale 1ns/1ps
module tb_top;
  reg         mclk = 1'b0, reset_n = 1'b0, req = 1'b0, rso = 1'b0;
  reg  [31:0] rw = 32'h0, ra = 32'h0, rb = 32'h0, rs = 32'h0;
  wire        iv, gwe, cwe, exc, cause, done, clm;
  wire [31:0] iw, av, bv, sv, gwd;
  wire [4:0]  gwa;
  wire [3:0]  cf;
  integer     miscompares = 0, cmp_count = 0, i;
  always #12.5 mclk = ~mclk;
  tcx_issue_model i_iss (.req(req), .req_word(rw), .req_a(ra), .req_b(rb), .req_s(rs), .issue_valid(iv),
    .instr_word(iw), .reg_a_value(av), .reg_b_value(bv), .source_reg_value(sv));
  tcx_unit i_dut (.mclk(mclk), .reset_n(reset_n), .issue_valid(iv), .instr_word(iw), .reg_a_value(av),
    .reg_b_value(bv), .source_reg_value(sv), .summary_overflow(rso), .gpr_we_q(gwe), .gpr_waddr_q(gwa),
    .gpr_wdata_q(gwd), .cf0_we_q(cwe), .first_condition_field_q(cf), .prog_exc_req_q(exc),
    .trap_cause_q(cause), .done_q(done), .claimed_q(clm));
  task chk(input [31:0] got, input [31:0] exp); begin
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  end endtask
  // one instruction, outputs settled on return
  task iss(input [31:0] w, input [31:0] a, input [31:0] b, input [31:0] s); begin
    @(posedge mclk); #1 req = 1'b1; rw = w; ra = a; rb = b; rs = s;
    @(posedge mclk); #1 req = 1'b0;
  end endtask
  task t_trap_reg; begin
    for (i = 0; i < 5; i = i + 1) begin
      iss({6'h1f, 5'h10 >> i, 10'h000, 10'h004, 1'b0}, 32'hffffffff, 32'h1, 32'h0);
      chk({exc, cause, done, clm, gwe}, {{2{i == 0 || i == 4}}, 3'b110});
    end
    iss({6'h1f, 5'h04, 10'h000, 10'h004, 1'b0}, 32'h7, 32'h7, 32'h0);
    chk({exc, gwe}, 2'b10);
    iss({6'h1f, 5'h1b, 10'h000, 10'h004, 1'b0}, 32'h7, 32'h7, 32'h0);
    chk({exc, done, gwe, cwe}, 4'b0100);
    iss({6'h1f, 5'h02, 10'h000, 10'h004, 1'b0}, 32'h5, 32'h7, 32'h0);
    chk({exc, cause, gwe}, 3'b110);
    iss({6'h1f, 5'h00, 10'h000, 10'h004, 1'b0}, 32'h7, 32'h7, 32'h0);
    chk({exc, done, clm, gwe}, 4'b0110);
  end endtask
  task t_trap_imm; begin
    iss({6'h03, 5'h04, 5'h00, 16'h8000}, 32'hffff8000, 32'h0, 32'h0);
    chk({exc, done}, 2'b11);
    iss({6'h03, 5'h10, 5'h00, 16'h8000}, 32'h00008000, 32'h0, 32'h0);
    chk({exc, done}, 2'b01);
    iss({6'h03, 5'h02, 5'h00, 16'h8000}, 32'h00008000, 32'h0, 32'h0);
    chk({exc, done}, 2'b11);
    iss({6'h03, 5'h08, 5'h00, 16'h0003}, 32'h5, 32'h0, 32'h0);
    chk({exc, done}, 2'b11);
  end endtask
  task t_xor; begin
    rso = 1'b1;
    iss({6'h1f, 5'h03, 5'h09, 5'h04, 10'h13c, 1'b1}, 32'h0, 32'h0f0f0000, 32'hf0f00001);
    chk({gwe, cwe, gwa, cf, exc}, {2'b11, 5'h09, 4'b1001, 1'b0});
    chk(gwd, 32'hffff0001);
    iss({6'h1f, 5'h03, 5'h05, 5'h04, 10'h13c, 1'b0}, 32'h0, 32'h5a5a5a5a, 32'h5a5a5a5a);
    chk({gwe, cwe, gwa, cf}, {2'b10, 5'h05, 4'b1001});
    chk(gwd, 32'h0);
    rso = 1'b0;
    iss({6'h1f, 5'h03, 5'h07, 5'h04, 10'h13c, 1'b1}, 32'h0, 32'h00000003, 32'h00000005);
    chk({gwe, cwe, gwa, cf}, {2'b11, 5'h07, 4'b0100});
    chk(gwd, 32'h6);
    iss({6'h1f, 5'h03, 5'h08, 5'h04, 10'h13c, 1'b1}, 32'h0, 32'h9, 32'h9);
    chk({gwe, cwe, gwa, cf}, {2'b11, 5'h08, 4'b0010});
    iss({6'h1a, 5'h01, 5'h02, 16'h8001}, 32'h0, 32'h0, 32'h12345678);
    chk({gwe, cwe, gwa}, {2'b10, 5'h02});
    chk(gwd, 32'h1234d679);
    iss({6'h1b, 5'h01, 5'h06, 16'h8001}, 32'h0, 32'h0, 32'h12345678);
    chk({gwe, cwe, gwa}, {2'b10, 5'h06});
    chk(gwd, 32'h92355678);
    iss({6'h1f, 5'h01, 5'h06, 5'h00, 10'h13d, 1'b1}, 32'h0, 32'h0, 32'h1);
    chk({done, clm, gwe, cwe, exc}, 5'b00000);
  end endtask
  task results; begin
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  end endtask
  // watchdog
  initial begin
    #20000;
    miscompares = miscompares + 1;
    results;
  end
  initial begin
    repeat (2) @(posedge mclk);
    #1 reset_n = 1'b1;
    t_trap_reg;
    t_trap_imm;
    t_xor;
    results;
  end
endmodule
